//--- lie_params.svh
// Offsets, field positions, reset values and counts for the local error/spurious block
`ifndef LIE_PARAMS_SVH
`define LIE_PARAMS_SVH

// Register byte offsets inside the 4-Kbyte window
`define LIE_OFF_SPURIOUS     12'h0F0
`define LIE_OFF_ERR_STATUS   12'h280
`define LIE_OFF_THERMAL      12'h330
`define LIE_OFF_PERF         12'h340
`define LIE_OFF_ERROR_LVE    12'h370
`define LIE_OFF_EXT_FEATURE  12'h400
`define LIE_OFF_EXT_BASE     12'h500
`define LIE_OFF_EXT_LAST     12'h530

// Vector entry field positions
`define LIE_VEC_LSB          0
`define LIE_VEC_MSB          7
`define LIE_MT_LSB           8
`define LIE_MT_MSB           10
`define LIE_PEND_BIT         12
`define LIE_MASK_BIT         16

// Spurious register field positions
`define LIE_SWEN_BIT         8
`define LIE_FOCUS_BIT        9

// Error status flag positions
`define LIE_ERR_SENT_ACC     2
`define LIE_ERR_RECV_ACC     3
`define LIE_ERR_SENT_VEC     5
`define LIE_ERR_RECV_VEC     6
`define LIE_ERR_BAD_ADDR     7

// Extended feature register count field
`define LIE_EXT_CNT_LSB      16
`define LIE_EXT_CNT_MSB      23
`define LIE_EXT_COUNT        8'h04

// Counts and limits
`define LIE_NUM_ENTRIES      7
`define LIE_FIRST_LEGAL_VEC  8'h10

// Reset values
`define LIE_RST_SPUR_VEC     8'hFF
`define LIE_RST_LVE_VEC      8'h00

`endif

//--- lie_pkg.sv
// Types shared by the local error/spurious block
package lie_pkg;

    // Delivery modes carried in a message or a vector entry
    typedef enum logic [2:0] {
        LIE_MT_FIXED  = 3'h0,
        LIE_MT_LOWEST = 3'h1,
        LIE_MT_SMI    = 3'h2,
        LIE_MT_RREAD  = 3'h3,
        LIE_MT_NMI    = 3'h4,
        LIE_MT_INIT   = 3'h5,
        LIE_MT_START  = 3'h6,
        LIE_MT_EXTERNAL_INTERRUPT_TYPE = 3'h7
    } lie_msg_type_t;

    // Data phase state of the bus slave
    typedef enum logic [1:0] {
        LIE_BUS_IDLE = 2'b01,
        LIE_BUS_DATA = 2'b10
    } lie_bus_state_t;

endpackage

//--- lie_local_irq.sv
// Local vector entries, error status and spurious register with an AHB-Lite slave
//
// Added by the designer: register access over AHB-Lite.
`include "lie_params.svh"

module lie_local_irq (
    input  wire logic                  clk,             // Core clock, 40 MHz
    input  wire logic                  rst,             // Asynchronous reset, active high
    // AHB-Lite slave
    input  wire logic                  hsel,            // Slave select for the 4-Kbyte window
    input  wire logic [31:0]           haddr,           // Byte address
    input  wire logic [1:0]            htrans,          // Transfer type
    input  wire logic                  hwrite,          // Write when high
    input  wire logic [2:0]            hsize,           // Transfer size
    input  wire logic                  hready,          // Bus ready
    input  wire logic [31:0]           hwdata,          // Write data
    output logic [31:0]                hrdata,          // Read data
    output logic                       hreadyout,       // Slave ready
    output logic                       hresp,           // Always OKAY
    // Interrupt sources
    input  wire logic                  thermal_evt,     // Thermal event pulse
    input  wire logic                  perf_ovf_evt,    // Counter overflow pulse
    input  wire logic [2:0]            ext_src_evt,     // Extended source pulses
    input  wire logic [5:0]            ext_src_sel,     // Two select bits per extended source
    // Delivery to the core interrupt handler
    output logic                       deliver_valid,   // A vector entry is pending
    output lie_pkg::lie_msg_type_t     deliver_type,    // Delivery mode of that entry
    output logic [7:0]                 deliver_vector,  // Vector of that entry, zero for SMI delivery
    input  wire logic                  deliver_ready,   // Core takes the delivery
    // Message traffic with peer controllers
    input  wire logic                  tx_no_accept,    // Own sent message accepted by none
    input  wire logic                  tx_bad_vector,   // Attempt to send an illegal vector
    input  wire logic                  rx_msg_valid,    // Incoming message strobe
    input  wire lie_pkg::lie_msg_type_t rx_msg_type,    // Incoming delivery mode
    input  wire logic [7:0]            rx_msg_vector,   // Incoming vector
    input  wire logic                  rx_none_accept,  // Received message accepted by nobody
    output logic                       rx_msg_accept,   // Incoming message accepted
    // Acknowledge path
    input  wire logic                  ack_req,         // Core acknowledges an interrupt
    input  wire logic [7:0]            ack_vector,      // Vector being acknowledged
    input  wire logic [7:0]            task_priority,   // Current task priority
    output logic                       ack_done,        // One-cycle answer to ack_req
    output logic [7:0]                 ack_out_vector,  // Vector handed to the core
    output logic                       ack_spurious,    // Answer is the spurious vector
    output logic                       ack_set_service, // Set the in-service bit for it
    // Focus check for lowest-priority arbitration
    input  wire logic                  focus_req,       // Lowest-priority message to check
    input  wire logic [7:0]            focus_vector,    // Its vector
    input  wire logic [255:0]          in_service_bits, // In-service vector
    input  wire logic [255:0]          request_bits,    // Request vector
    output logic                       focus_hit        // This core is the focus
);
    import lie_pkg::*;

    localparam int NE = `LIE_NUM_ENTRIES;

    // Fixed delivery with a vector below 16 is illegal
    function automatic logic bad_vec(input lie_msg_type_t mt, input logic [7:0] v);
        bad_vec = (mt == LIE_MT_FIXED) && (v < `LIE_FIRST_LEGAL_VEC);
    endfunction

    // Offsets that hold a register
    function automatic logic is_mapped(input logic [11:0] off);
        is_mapped = (off == `LIE_OFF_SPURIOUS) || (off == `LIE_OFF_ERR_STATUS) ||
                    (off == `LIE_OFF_THERMAL) || (off == `LIE_OFF_PERF) ||
                    (off == `LIE_OFF_ERROR_LVE) || (off == `LIE_OFF_EXT_FEATURE) ||
                    ((off >= `LIE_OFF_EXT_BASE) && (off <= `LIE_OFF_EXT_LAST) &&
                     (off[3:0] == 4'h0));
    endfunction

    // Entry index for an offset, NE when none
    function automatic logic [2:0] entry_of(input logic [11:0] off);
        if (off == `LIE_OFF_THERMAL) begin
            entry_of = 3'h0;
        end else if (off == `LIE_OFF_PERF) begin
            entry_of = 3'h1;
        end else if (off == `LIE_OFF_ERROR_LVE) begin
            entry_of = 3'h2;
        end else if ((off >= `LIE_OFF_EXT_BASE) && (off <= `LIE_OFF_EXT_LAST) &&
                     (off[3:0] == 4'h0)) begin
            entry_of = 3'(3 + off[5:4]);
        end else begin
            entry_of = 3'(NE);
        end
    endfunction

    // Register state
    logic [7:0]           spur_vec;        // Spurious vector
    logic                 software_enable; // Global software enable
    logic                 focus_check_ctl; // One disables focus checking
    logic [7:0]           err_status;      // Captured error flags
    logic [7:0]           err_int, err_prev; // Internal errors now and one cycle ago
    logic [7:0]           lve_vec  [NE];   // Entry vector fields
    lie_msg_type_t        lve_type [NE];   // Entry message type fields
    logic [NE-1:0]        lve_mask;        // Entry mask bits
    logic [NE-1:0]        lve_pend;        // Entry delivery pending bits

    // Bus data phase registers
    lie_bus_state_t       bus_state;       // Idle or in a data phase
    logic                 dp_write;        // Data phase is a write
    logic [11:0]          dp_off;          // Data phase offset

    // Address phase decode
    wire                  ap_valid  = hsel && htrans[1] && hready;
    wire [11:0]           ap_off    = haddr[11:0];
    wire                  ap_bad    = ap_valid && !is_mapped(ap_off);
    wire                  dp_wr     = (bus_state == LIE_BUS_DATA) && dp_write;
    wire [2:0]            dp_entry  = entry_of(dp_off);
    wire                  wr_spur   = dp_wr && (dp_off == `LIE_OFF_SPURIOUS);
    wire                  wr_err    = dp_wr && (dp_off == `LIE_OFF_ERR_STATUS);
    wire [2:0]            ap_entry  = entry_of(ap_off);

    // Source events per entry; extended sources pick their entry
    logic [NE-1:0]        evt;
    wire                  err_evt;
    always_comb begin
        evt    = '0;
        evt[0] = thermal_evt;
        evt[1] = perf_ovf_evt;
        evt[2] = err_evt;
        for (int s = 0; s < 3; s++) begin
            if (ext_src_evt[s]) begin
                evt[3 + ext_src_sel[2*s +: 2]] = 1'b1;
            end
        end
    end

    // An entry takes an event only when unmasked and enabled
    logic [NE-1:0]        take;
    logic [NE-1:0]        take_bad;
    always_comb begin
        for (int i = 0; i < NE; i++) begin
            take[i]     = evt[i] && !lve_mask[i] && software_enable;
            take_bad[i] = take[i] && bad_vec(lve_type[i], lve_vec[i]);
        end
    end

    // Lowest index pending entry goes to the core first
    logic [2:0]           sel;
    always_comb begin
        sel = 3'(NE);
        for (int i = NE - 1; i >= 0; i--) begin
            if (lve_pend[i]) begin
                sel = 3'(i);
            end
        end
    end
    wire                  sel_ok   = (sel != 3'(NE));
    wire                  deliver_fire = deliver_valid && deliver_ready;

    assign deliver_valid  = sel_ok;
    assign deliver_type   = sel_ok ? lve_type[sel] : LIE_MT_FIXED;
    assign deliver_vector = (!sel_ok) ? 8'h00 :
                            (lve_type[sel] == LIE_MT_SMI) ? 8'h00 : lve_vec[sel];

    // Incoming message checks
    wire                  rx_maskable = (rx_msg_type == LIE_MT_FIXED) ||
                                        (rx_msg_type == LIE_MT_LOWEST) ||
                                        (rx_msg_type == LIE_MT_EXTERNAL_INTERRUPT_TYPE);
    wire                  rx_bad    = rx_msg_valid && bad_vec(rx_msg_type, rx_msg_vector);
    assign rx_msg_accept  = rx_msg_valid && !rx_bad &&
                            (software_enable || !rx_maskable);

    // Errors found in this cycle
    logic [7:0]           err_now;
    always_comb begin
        err_now = 8'h00;
        err_now[`LIE_ERR_SENT_ACC] = tx_no_accept;
        err_now[`LIE_ERR_RECV_ACC] = rx_msg_valid && rx_none_accept;
        err_now[`LIE_ERR_SENT_VEC] = tx_bad_vector || (|take_bad);
        err_now[`LIE_ERR_RECV_VEC] = rx_bad;
        err_now[`LIE_ERR_BAD_ADDR] = ap_bad;
    end
    // A flag newly set in the flops asks for an error interrupt; no loop through err_now
    assign err_evt = |(err_int & ~err_prev);

    // Focus is the in-service or request bit; setting the control disables it
    assign focus_hit = focus_req && !focus_check_ctl &&
                       (in_service_bits[focus_vector] || request_bits[focus_vector]);

    // Read data for the address phase offset
    logic [31:0]          rd_val;
    always_comb begin
        rd_val = 32'h0000_0000;
        if (ap_off == `LIE_OFF_SPURIOUS) begin
            rd_val[`LIE_VEC_MSB:`LIE_VEC_LSB] = spur_vec;
            rd_val[`LIE_SWEN_BIT]  = software_enable;
            rd_val[`LIE_FOCUS_BIT] = focus_check_ctl;
        end else if (ap_off == `LIE_OFF_ERR_STATUS) begin
            rd_val[7:0] = err_status;
        end else if (ap_off == `LIE_OFF_EXT_FEATURE) begin
            rd_val[`LIE_EXT_CNT_MSB:`LIE_EXT_CNT_LSB] = `LIE_EXT_COUNT;
        end else if (ap_entry != 3'(NE)) begin
            rd_val[`LIE_VEC_MSB:`LIE_VEC_LSB] = lve_vec[ap_entry];
            rd_val[`LIE_MT_MSB:`LIE_MT_LSB]   = lve_type[ap_entry];
            rd_val[`LIE_PEND_BIT]             = lve_pend[ap_entry];
            rd_val[`LIE_MASK_BIT]             = lve_mask[ap_entry] || !software_enable;
        end
    end

    assign hreadyout = 1'b1;   // Zero wait states; every access ends in one data phase
    assign hresp     = 1'b0;   // Unmapped offsets read zero and still answer OKAY

    // Bus phase tracking and registered read data
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_state <= LIE_BUS_IDLE;
            dp_write  <= 1'b0;
            dp_off    <= 12'h000;
            hrdata    <= 32'h0000_0000;
        end else begin
            case (bus_state)
                LIE_BUS_IDLE,
                LIE_BUS_DATA: begin
                    bus_state <= ap_valid ? LIE_BUS_DATA : LIE_BUS_IDLE;
                end
                default: begin
                    bus_state <= LIE_BUS_IDLE;
                end
            endcase
            dp_write <= ap_valid && hwrite;
            dp_off   <= ap_off;
            hrdata   <= (ap_valid && !hwrite) ? rd_val : 32'h0000_0000;
        end
    end

    // Spurious register; enable resumes on a write of one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            spur_vec        <= `LIE_RST_SPUR_VEC;
            software_enable <= 1'b0;
            focus_check_ctl <= 1'b0;
        end else if (wr_spur) begin
            spur_vec        <= hwdata[`LIE_VEC_MSB:`LIE_VEC_LSB];
            software_enable <= hwdata[`LIE_SWEN_BIT];
            focus_check_ctl <= hwdata[`LIE_FOCUS_BIT];
        end
    end

    // Error capture: a write copies and clears, a new error in that cycle survives
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            err_status <= 8'h00;
            err_int    <= 8'h00;
            err_prev   <= 8'h00;
        end else begin
            err_prev   <= err_int;
            err_int    <= wr_err ? err_now : (err_int | err_now);
            if (wr_err) begin
                err_status <= err_int;
            end
        end
    end

    // Vector entries: masks forced while disabled, pending set wins over delivery clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NE; i++) begin
                lve_vec[i]  <= `LIE_RST_LVE_VEC;
                lve_type[i] <= LIE_MT_FIXED;
            end
            lve_mask <= '1;
            lve_pend <= '0;
        end else begin
            for (int i = 0; i < NE; i++) begin
                if (dp_wr && (dp_entry == 3'(i))) begin
                    lve_vec[i]  <= hwdata[`LIE_VEC_MSB:`LIE_VEC_LSB];
                    lve_type[i] <= lie_msg_type_t'(hwdata[`LIE_MT_MSB:`LIE_MT_LSB]);
                    lve_mask[i] <= hwdata[`LIE_MASK_BIT] || !software_enable;
                end else if (!software_enable) begin
                    lve_mask[i] <= 1'b1;
                end
                if (take[i] && !take_bad[i]) begin
                    lve_pend[i] <= 1'b1;
                end else if (deliver_fire && (sel == 3'(i))) begin
                    lve_pend[i] <= 1'b0;
                end
            end
        end
    end

    // Acknowledge: raised task priority turns the answer spurious
    wire                  ack_is_spur = task_priority[7:4] >= ack_vector[7:4];
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_done        <= 1'b0;
            ack_out_vector  <= 8'h00;
            ack_spurious    <= 1'b0;
            ack_set_service <= 1'b0;
        end else begin
            ack_done        <= ack_req;
            ack_out_vector  <= !ack_req ? 8'h00 : (ack_is_spur ? spur_vec : ack_vector);
            ack_spurious    <= ack_req && ack_is_spur;
            ack_set_service <= ack_req && !ack_is_spur;
        end
    end

endmodule

//--- lie_local_irq_sva.sv
// Port-level checks for the local error/spurious block
module lie_local_irq_sva import lie_pkg::*; (
    input wire logic                   clk,
    input wire logic                   rst,
    input wire logic                   hsel,
    input wire logic [31:0]            haddr,
    input wire logic [1:0]             htrans,
    input wire logic                   hwrite,
    input wire logic                   hready,
    input wire logic [31:0]            hrdata,
    input wire logic                   hreadyout,
    input wire logic                   hresp,
    input wire logic                   deliver_valid,
    input wire lie_pkg::lie_msg_type_t deliver_type,
    input wire logic [7:0]             deliver_vector,
    input wire logic                   rx_msg_valid,
    input wire lie_pkg::lie_msg_type_t rx_msg_type,
    input wire logic [7:0]             rx_msg_vector,
    input wire logic                   rx_msg_accept,
    input wire logic                   ack_req,
    input wire logic [7:0]             ack_vector,
    input wire logic [7:0]             task_priority,
    input wire logic                   ack_done,
    input wire logic [7:0]             ack_out_vector,
    input wire logic                   ack_spurious,
    input wire logic                   ack_set_service
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Read address phase, and a late-priority acknowledge
    sequence s_rd;
        hsel && htrans[1] && hready && !hwrite;
    endsequence
    sequence s_ack_late;
        ack_req && task_priority[7:4] >= ack_vector[7:4];
    endsequence
    property p_okay;
        hreadyout && !hresp;
    endproperty
    a_okay: assert property (p_okay) else $error("slave not ready or not OKAY");
    // Read data only stands in the data phase of a read
    property p_rd_idle;
        !$past(hsel && htrans[1] && hready && !hwrite) |-> hrdata == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside data phase");
    property p_feat;
        s_rd ##0 haddr[11:0] == 12'h400 |=> hrdata[23:16] == 8'h04;
    endproperty
    a_feat: assert property (p_feat) else $error("extended count wrong");
    property p_smi;
        deliver_valid && deliver_type == LIE_MT_SMI |-> deliver_vector == 8'h00;
    endproperty
    a_smi: assert property (p_smi) else $error("SMI delivery vector not zero");
    property p_spur;
        s_ack_late |=> ack_done && ack_spurious && !ack_set_service;
    endproperty
    a_spur: assert property (p_spur) else $error("late acknowledge not spurious");
    property p_spur_svc;
        ack_spurious |-> !ack_set_service;
    endproperty
    a_spur_svc: assert property (p_spur_svc) else $error("spurious touched service");
    property p_ack_ok;
        ack_req && task_priority[7:4] < ack_vector[7:4] |=> ack_done && !ack_spurious
            && ack_set_service && ack_out_vector == $past(ack_vector);
    endproperty
    a_ack_ok: assert property (p_ack_ok) else $error("acknowledge vector wrong");
    property p_ack_once;
        ack_done |-> $past(ack_req);
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("answer without request");
    property p_rx_sys;
        rx_msg_valid && rx_msg_vector >= 8'h10 && rx_msg_type inside
            {LIE_MT_SMI, LIE_MT_RREAD, LIE_MT_NMI, LIE_MT_INIT, LIE_MT_START} |-> rx_msg_accept;
    endproperty
    a_rx_sys: assert property (p_rx_sys) else $error("system message refused");
    property p_rx_bad;
        rx_msg_accept |-> rx_msg_valid && !(rx_msg_type == LIE_MT_FIXED && rx_msg_vector < 8'h10);
    endproperty
    a_rx_bad: assert property (p_rx_bad) else $error("illegal vector accepted");
endmodule

bind lie_local_irq lie_local_irq_sva i_sva (.clk, .rst, .hsel, .haddr, .htrans, .hwrite,
    .hready, .hrdata, .hreadyout, .hresp, .deliver_valid, .deliver_type, .deliver_vector,
    .rx_msg_valid, .rx_msg_type, .rx_msg_vector, .rx_msg_accept, .ack_req, .ack_vector,
    .task_priority, .ack_done, .ack_out_vector, .ack_spurious, .ack_set_service);

//--- lie_core_model.sv
// Core interrupt handler stand-in that takes deliveries and may stall
module lie_core_model import lie_pkg::*; (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   stall,          // Hold off taking deliveries
    input  wire logic                   deliver_valid,
    input  wire lie_pkg::lie_msg_type_t deliver_type,
    input  wire logic [7:0]             deliver_vector,
    output logic                        deliver_ready,
    output logic [7:0]                  taken_vec,      // Last vector taken
    output lie_pkg::lie_msg_type_t      taken_type,     // Last mode taken
    output logic [7:0]                  taken_cnt       // Deliveries taken so far
);
    timeunit 1ns;
    timeprecision 1ps;
    // Ready moves only just after an edge; each delivery is recorded at its closing edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            deliver_ready <= 1'b0;
            taken_cnt     <= 8'h00;
            taken_vec     <= 8'h00;
            taken_type    <= LIE_MT_FIXED;
        end else begin
            deliver_ready <= !stall;
            if (deliver_valid && deliver_ready) begin
                taken_cnt  <= taken_cnt + 8'h01;
                taken_vec  <= deliver_vector;
                taken_type <= deliver_type;
            end
        end
    end
endmodule

//--- lie_local_irq_bench.sv
// Self-checking bench for the local error/spurious block
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module lie_local_irq_bench import lie_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic          clk, rst, hsel, hwrite, thermal_evt, perf_ovf_evt, tx_no_accept, stall;
    logic          tx_bad_vector, rx_msg_valid, rx_none_accept, ack_req, focus_req;
    logic          hreadyout, hresp, deliver_valid, deliver_ready, rx_msg_accept, ack_done;
    logic          ack_spurious, ack_set_service, focus_hit;
    logic [31:0]   haddr, hwdata, hrdata, rq;
    logic [1:0]    htrans;
    logic [2:0]    hsize, ext_src_evt;
    logic [5:0]    ext_src_sel;
    logic [7:0]    rx_msg_vector, ack_vector, task_priority, focus_vector, deliver_vector;
    logic [7:0]    ack_out_vector, taken_vec, taken_cnt, seen;
    logic [255:0]  in_service_bits, request_bits;
    lie_msg_type_t rx_msg_type, deliver_type, taken_type;
    lie_msg_type_t mt [4] = '{LIE_MT_FIXED, LIE_MT_SMI, LIE_MT_NMI, LIE_MT_EXTERNAL_INTERRUPT_TYPE};
    int            bad_count, checked;

    lie_local_irq i_dut (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .thermal_evt, .perf_ovf_evt,
        .ext_src_evt, .ext_src_sel, .deliver_valid, .deliver_type, .deliver_vector,
        .deliver_ready, .tx_no_accept, .tx_bad_vector, .rx_msg_valid, .rx_msg_type,
        .rx_msg_vector, .rx_none_accept, .rx_msg_accept, .ack_req, .ack_vector, .task_priority,
        .ack_done, .ack_out_vector, .ack_spurious, .ack_set_service, .focus_req, .focus_vector,
        .in_service_bits, .request_bits, .focus_hit);
    lie_core_model i_core (.clk, .rst, .stall, .deliver_valid, .deliver_type, .deliver_vector,
        .deliver_ready, .taken_vec, .taken_type, .taken_cnt);

    // 40 MHz core clock
    always #12.5 clk = ~clk;

    // One single word transfer; read data is taken at the closing edge
    task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, 20'h0, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(a, 1'b1, d, rq);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0, rq);
        `CHK("hrdata", e, rq)
    endtask
    // Single-cycle pulse: 0 thermal, 1 counter, 2 unaccepted send, 3 bad send vector
    task automatic pulse(input int k);
        @(posedge clk);
        {tx_bad_vector, tx_no_accept, perf_ovf_evt, thermal_evt} <= 4'h1 << k;
        @(posedge clk);
        {tx_bad_vector, tx_no_accept, perf_ovf_evt, thermal_evt} <= 4'h0;
    endtask
    // Wait for exactly one more delivery at the core and check its vector
    task automatic take(input logic [7:0] ev);
        seen = seen + 8'h01;
        for (int i = 0; i < 40 && taken_cnt !== seen; i++) @(posedge clk);
        `CHK("taken_cnt", seen, taken_cnt)
        `CHK("taken_vec", ev, taken_vec)
    endtask
    task automatic rx(input lie_msg_type_t t, input logic [7:0] v, input logic na, ea);
        @(posedge clk);
        {rx_msg_valid, rx_none_accept, rx_msg_vector} <= {1'b1, na, v};
        rx_msg_type <= t;
        @(negedge clk);
        `CHK("rx_msg_accept", ea, rx_msg_accept)
        @(posedge clk);
        rx_msg_valid <= 1'b0;
    endtask
    task automatic ack(input logic [7:0] v, tp, ev, input logic sp);
        @(posedge clk);
        {ack_req, ack_vector, task_priority} <= {1'b1, v, tp};
        @(posedge clk);
        ack_req <= 1'b0;
        @(negedge clk);
        `CHK("ack_out_vector", ev, ack_out_vector)
        `CHK("ack_spurious", sp, ack_spurious)
        `CHK("ack_set_service", !sp, ack_set_service)
    endtask
    task automatic focus(input logic [255:0] s, r, input logic eh);
        @(posedge clk);
        {focus_req, focus_vector, in_service_bits, request_bits} <= {1'b1, 8'h33, s, r};
        @(negedge clk);
        `CHK("focus_hit", eh, focus_hit)
    endtask
    task automatic results();
        if (bad_count == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        results();
    end

    initial begin
        {clk, rst, hsel, hwrite, thermal_evt, perf_ovf_evt, tx_no_accept, stall} = 8'h40;
        {tx_bad_vector, rx_msg_valid, rx_none_accept, ack_req, focus_req} = 5'h0;
        {haddr, hwdata, htrans, hsize, ext_src_evt, ext_src_sel} = {64'h0, 2'h0, 3'h2, 9'h0};
        {rx_msg_vector, ack_vector, task_priority, focus_vector, seen} = 40'h0;
        {in_service_bits, request_bits} = 512'h0;
        rx_msg_type = LIE_MT_FIXED;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(12'h0F0, 32'h0000_00FF);
        rd(12'h330, 32'h0001_0000);
        rd(12'h400, 32'h0004_0000);
        wr(12'h330, 32'h30);
        rd(12'h330, 32'h0001_0030);
        wr(12'h0F0, 32'h1F0);
        rd(12'h0F0, 32'h1F0);
        wr(12'h330, 32'hFFFE_E030);
        rd(12'h330, 32'h30);
        // Thermal delivery must wait out a stalled core, then go once
        stall <= 1'b1;
        pulse(0);
        repeat (4) @(posedge clk);
        @(negedge clk);
        `CHK("deliver_vector", 8'h30, deliver_vector)
        @(posedge clk);
        stall <= 1'b0;
        take(8'h30);
        pulse(1);
        repeat (8) @(posedge clk);
        `CHK("deliver_valid", 1'b0, deliver_valid)
        foreach (mt[i]) begin
            wr(12'h340, {21'h0, mt[i], 8'h41});
            pulse(1);
            take(mt[i] == LIE_MT_SMI ? 8'h00 : 8'h41);
            `CHK("taken_type", mt[i], taken_type)
        end
        for (int i = 0; i < 4; i++) begin
            wr(12'h500 + 12'(i * 16), 32'h60 + i);
            @(posedge clk);
            {ext_src_sel, ext_src_evt} <= {6'(i) << (2 * (i % 3)), 3'h1 << (i % 3)};
            @(posedge clk);
            ext_src_evt <= 3'h0;
            take(8'h60 + 8'(i));
        end
        // Each newly raised error goes out through the error entry
        wr(12'h370, 32'h70);
        wr(12'h330, 32'h05);
        pulse(0);
        take(8'h70);
        wr(12'h280, 32'h0);
        rd(12'h280, 32'h20);
        pulse(2);
        take(8'h70);
        rx(LIE_MT_FIXED, 8'h44, 1'b1, 1'b1);
        take(8'h70);
        rx(LIE_MT_FIXED, 8'h03, 1'b0, 1'b0);
        take(8'h70);
        rd(12'h200, 32'h0);
        take(8'h70);
        pulse(3);
        take(8'h70);
        wr(12'h280, 32'h0);
        rd(12'h280, 32'hEC);
        wr(12'h280, 32'h0);
        rd(12'h280, 32'h0);
        ack(8'h50, 8'h60, 8'hF0, 1'b1);
        ack(8'h50, 8'h50, 8'hF0, 1'b1);
        ack(8'h50, 8'h40, 8'h50, 1'b0);
        focus(256'h1 << 8'h33, 256'h0, 1'b1);
        focus(256'h0, 256'h1 << 8'h33, 1'b1);
        focus(256'h0, 256'h1 << 8'h32, 1'b0);
        // Disabled controller: masks forced, only system messages taken
        wr(12'h0F0, 32'h2F0);
        focus(256'h1 << 8'h33, 256'h0, 1'b0);
        wr(12'h340, 32'h741);
        rd(12'h340, 32'h0001_0741);
        for (int t = 0; t < 8; t++) rx(lie_msg_type_t'(3'(t)), 8'h44, 1'b0, t > 1 && t < 7);
        results();
    end
endmodule
